// *** logic/stp_consts.svh ***
// Constants for the synchronous TFT pixel port: offsets, fields, resets, timing
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define STP_OFF_CTRL    8'h00
`define STP_OFF_SIZE    8'h04
`define STP_OFF_HGAP    8'h08
`define STP_OFF_VGAP    8'h0c
`define STP_OFF_SYNC    8'h10
`define STP_OFF_STAT    8'h14

// ************************************************************
// Field positions
// ************************************************************
`define STP_CTL_EN      0
`define STP_CTL_PCLK_HI 1
`define STP_CTL_HS_HI   2
`define STP_CTL_VS_HI   3
`define STP_CTL_SYNC_EN 4
`define STP_CTL_MODE    6:5
`define STP_MODE_COLOUR 2'h1
`define STP_FLD_LO      11:0
`define STP_FLD_HI      27:16

// ************************************************************
// Reset values
// ************************************************************
`define STP_RST_CTRL    32'h0000_0030
`define STP_RST_SIZE    32'h00f0_0140
`define STP_RST_HGAP    32'h0010_0028
`define STP_RST_VGAP    32'h0004_000c
`define STP_RST_SYNC    32'h0002_0008

// ************************************************************
// Bus answers and timing
// ************************************************************
`define STP_RESP_OK     2'h0
`define STP_RESP_ERR    2'h2
`define STP_PCLK_NS     160
`define STP_SYS_NS      20

`endif

// *** logic/stp_pkg.sv ***
// Types shared by the synchronous TFT pixel port modules
package stp_pkg;

    // Frame settings, latched once per frame
    typedef struct packed {
        logic        on;
        logic        pclk_hi;
        logic        hs_hi;
        logic        vs_hi;
        logic        sync_en;
        logic [11:0] h_act;
        logic [11:0] v_act;
        logic [11:0] horizontal_back_gap;
        logic [11:0] horizontal_front_gap;
        logic [11:0] vertical_back_gap;
        logic [11:0] vertical_front_gap;
        logic [11:0] hsw;
        logic [11:0] vsw;
    } stp_cfg_t;

    // Register slave state
    typedef struct packed {
        logic        awr;
        logic        wr;
        logic        bv;
        logic        arr;
        logic        rv;
        logic [7:0]  awa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] size;
        logic [31:0] hgap;
        logic [31:0] vgap;
        logic [31:0] sync;
    } stp_axi_st_t;

endpackage

// *** logic/stp_axi_regs.sv ***
// AXI4-Lite register slave holding the pixel port settings
`include "stp_consts.svh"

module stp_axi_regs (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic [31:0] i_status,
    output logic [31:0]      o_ctrl,
    output logic [31:0]      o_size,
    output logic [31:0]      o_hgap,
    output logic [31:0]      o_vgap,
    output logic [31:0]      o_sync
);

    localparam stp_pkg::stp_axi_st_t RST = '{
        awr: 1'b1, wr: 1'b1, bv: 1'b0, arr: 1'b1, rv: 1'b0,
        awa: 8'h00, wd: 32'h0, ws: 4'h0,
        bresp: `STP_RESP_OK, rresp: `STP_RESP_OK, rdata: 32'h0,
        ctrl: `STP_RST_CTRL, size: `STP_RST_SIZE, hgap: `STP_RST_HGAP,
        vgap: `STP_RST_VGAP, sync: `STP_RST_SYNC};

    stp_pkg::stp_axi_st_t s_r;
    stp_pkg::stp_axi_st_t s_nxt;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction

    // Address and data are taken in either order; the answer follows both
    always_comb
    begin
        s_nxt = s_r;
        if (i_awvalid && s_r.awr)
        begin
            s_nxt.awa = i_awaddr;
            s_nxt.awr = 1'b0;
        end
        if (i_wvalid && s_r.wr)
        begin
            s_nxt.wd = i_wdata;
            s_nxt.ws = i_wstrb;
            s_nxt.wr = 1'b0;
        end
        if (!s_r.awr && !s_r.wr && !s_r.bv)
        begin
            s_nxt.bv    = 1'b1;
            s_nxt.bresp = `STP_RESP_OK;
            case (s_r.awa)
                `STP_OFF_CTRL: s_nxt.ctrl = merge(s_r.ctrl, s_r.wd, s_r.ws);
                `STP_OFF_SIZE: s_nxt.size = merge(s_r.size, s_r.wd, s_r.ws);
                `STP_OFF_HGAP: s_nxt.hgap = merge(s_r.hgap, s_r.wd, s_r.ws);
                `STP_OFF_VGAP: s_nxt.vgap = merge(s_r.vgap, s_r.wd, s_r.ws);
                `STP_OFF_SYNC: s_nxt.sync = merge(s_r.sync, s_r.wd, s_r.ws);
                `STP_OFF_STAT: s_nxt.bresp = `STP_RESP_OK; // Read-only, write dropped
                default:       s_nxt.bresp = `STP_RESP_ERR;
            endcase
        end
        if (s_r.bv && i_bready)
        begin
            s_nxt.bv  = 1'b0;
            s_nxt.awr = 1'b1;
            s_nxt.wr  = 1'b1;
        end
        // Read data is returned at the same edge that takes the address
        if (i_arvalid && s_r.arr)
        begin
            s_nxt.arr   = 1'b0;
            s_nxt.rv    = 1'b1;
            s_nxt.rresp = `STP_RESP_OK;
            case (i_araddr)
                `STP_OFF_CTRL: s_nxt.rdata = s_r.ctrl;
                `STP_OFF_SIZE: s_nxt.rdata = s_r.size;
                `STP_OFF_HGAP: s_nxt.rdata = s_r.hgap;
                `STP_OFF_VGAP: s_nxt.rdata = s_r.vgap;
                `STP_OFF_SYNC: s_nxt.rdata = s_r.sync;
                `STP_OFF_STAT: s_nxt.rdata = i_status;
                default:
                begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = `STP_RESP_ERR;
                end
            endcase
        end
        if (s_r.rv && i_rready)
        begin
            s_nxt.rv  = 1'b0;
            s_nxt.arr = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            s_r <= RST;
        else
            s_r <= s_nxt;
    end

    assign o_awready = s_r.awr;
    assign o_wready  = s_r.wr;
    assign o_bvalid  = s_r.bv;
    assign o_bresp   = s_r.bresp;
    assign o_arready = s_r.arr;
    assign o_rvalid  = s_r.rv;
    assign o_rresp   = s_r.rresp;
    assign o_rdata   = s_r.rdata;
    assign o_ctrl    = s_r.ctrl;
    assign o_size    = s_r.size;
    assign o_hgap    = s_r.hgap;
    assign o_vgap    = s_r.vgap;
    assign o_sync    = s_r.sync;

endmodule

// *** logic/stp_top.sv ***
// Synchronous TFT colour pixel port: timing, pixel clock and RGB666 output
`include "stp_consts.svh"

// What this block does
// - Of four panel kinds, only TFT colour drives syncs, valid and data; the pixel clock runs in all.
// - Drives 22 lines: line sync, frame sync, valid, clock, 18 RGB.
// - Red on bus bits 17..12, green 11..6, blue 5..0.
// - Line sync pulse ends a line; following valid pixels are next line.
// - Frame sync goes active to end the current frame.
// - Valid is high only while the bus holds pixels; panel latches on clock.
// - High clock polarity: data changes on falling edge, latched on rising.
// - Low clock polarity: data changes on rising edge, latched on falling.
// - Pixel output is limited to 18 data lines.
// - Wider pixels lose low bits of each colour; upper bits pass unchanged.
// - Truncation only: no dithering or filtering.
// - Works for panels using only valid, clock and data; syncs can be off.
// - No serial command port is used for panel start-up.
// - Programmable back gap before and front gap after active pixels.
// - Programmable line counts before and after the active lines.
// - Line period equals active width plus back gap plus front gap.
// - Line and frame sync active levels are chosen independently.
module stp_top #(
    parameter int IN_BITS = 8
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst,
    input  wire logic [7:0]           i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [7:0]           i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    input  wire logic [3*IN_BITS-1:0] i_pix_data,
    input  wire logic                 i_pix_valid,
    output logic                      o_pix_ready,
    output logic                      o_line_sync_pin,
    output logic                      o_frame_sync_pin,
    output logic                      o_pixel_valid_pin,
    output logic                      o_pixel_clock_pin,
    output logic [17:0]               o_rgb_pixel_bus
);

    localparam int CW   = 13;
    localparam int OB   = 6;
    localparam int HALF = `STP_PCLK_NS / `STP_SYS_NS / 2;
    localparam int SLOT_AFTER = 2 * HALF + 1; // Ticks from one slot edge to the next one's pins

    typedef struct packed {
        stp_pkg::stp_cfg_t    cfg;
        logic [7:0]           div;
        logic                 pclk;
        logic [CW-1:0]        hcnt;
        logic [CW-1:0]        vcnt;
        logic [3*IN_BITS-1:0] hold;
        logic                 full;
        logic                 rdy;
        logic                 hs;
        logic                 vs;
        logic                 de;
        logic [17:0]          rgb;
    } stp_top_st_t;

    stp_top_st_t s_r;
    stp_top_st_t s_nxt;
    logic        adv;
    logic [31:0] ctrl_w;
    logic [31:0] size_w;
    logic [31:0] hgap_w;
    logic [31:0] vgap_w;
    logic [31:0] sync_w;
    logic [31:0] status_w;
    logic [CW-1:0] htot_q;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Sum of a gap, an active span and a gap
    function automatic logic [CW-1:0] span(input logic [11:0] a,
                                           input logic [11:0] b,
                                           input logic [11:0] c);
        return CW'(a) + CW'(b) + CW'(c);
    endfunction

    // Only the upper six bits of each colour survive; no rounding
    function automatic logic [17:0] trunc(input logic [3*IN_BITS-1:0] p);
        return {p[3*IN_BITS-1 -: OB], p[2*IN_BITS-1 -: OB], p[IN_BITS-1 -: OB]};
    endfunction

    // Register words into one frame setting
    function automatic stp_pkg::stp_cfg_t unpack(input logic [31:0] ct,
                                                 input logic [31:0] sz,
                                                 input logic [31:0] hg,
                                                 input logic [31:0] vg,
                                                 input logic [31:0] sy);
        stp_pkg::stp_cfg_t c;
        c.on      = ct[`STP_CTL_EN] && (ct[`STP_CTL_MODE] == `STP_MODE_COLOUR);
        c.pclk_hi = ct[`STP_CTL_PCLK_HI];
        c.hs_hi   = ct[`STP_CTL_HS_HI];
        c.vs_hi   = ct[`STP_CTL_VS_HI];
        c.sync_en = ct[`STP_CTL_SYNC_EN];
        c.h_act   = sz[`STP_FLD_LO];
        c.v_act   = sz[`STP_FLD_HI];
        c.horizontal_back_gap     = hg[`STP_FLD_LO];
        c.horizontal_front_gap     = hg[`STP_FLD_HI];
        c.vertical_back_gap     = vg[`STP_FLD_LO];
        c.vertical_front_gap     = vg[`STP_FLD_HI];
        c.hsw     = sy[`STP_FLD_LO];
        c.vsw     = sy[`STP_FLD_HI];
        return c;
    endfunction

    // ************************************************************
    // Register slave; no serial command port exists in this block
    // ************************************************************

    assign status_w = {15'h0, s_r.cfg.on, 3'h0, s_r.vcnt};

    stp_axi_regs u_regs (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_awaddr  (i_awaddr),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .o_bresp   (o_bresp),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .i_araddr  (i_araddr),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .i_status  (status_w),
        .o_ctrl    (ctrl_w),
        .o_size    (size_w),
        .o_hgap    (hgap_w),
        .o_vgap    (vgap_w),
        .o_sync    (sync_w)
    );

    // ************************************************************
    // Timing generator
    // ************************************************************

    // Pixel clock toggles every HALF ticks; counters and output pins advance on its data-change edge
    always_comb
    begin
        stp_pkg::stp_cfg_t c;
        logic              h_in;
        logic              v_in;
        logic [CW-1:0]     htot;
        logic [CW-1:0]     vtot;
        c     = s_r.cfg;
        h_in  = 1'b0;
        v_in  = 1'b0;
        htot  = '0;
        vtot  = '0;
        adv   = 1'b0;
        s_nxt = s_r;
        if (s_r.div == 8'(HALF - 1))
        begin
            s_nxt.div  = 8'h00;
            s_nxt.pclk = ~s_r.pclk;
            adv        = (~s_r.pclk) != s_r.cfg.pclk_hi;
        end
        else
            s_nxt.div = s_r.div + 8'h01;
        if (adv)
        begin
            // Settings only change at the first pixel slot of a frame
            if (s_r.hcnt == '0 && s_r.vcnt == '0)
            begin
                c         = unpack(ctrl_w, size_w, hgap_w, vgap_w, sync_w);
                s_nxt.cfg = c;
            end
            htot = span(c.horizontal_back_gap, c.h_act, c.horizontal_front_gap);
            vtot = span(c.vertical_back_gap, c.v_act, c.vertical_front_gap);
            h_in = s_r.hcnt >= CW'(c.horizontal_back_gap) && s_r.hcnt < span(c.horizontal_back_gap, c.h_act, 12'h0);
            v_in = s_r.vcnt >= CW'(c.vertical_back_gap) && s_r.vcnt < span(c.vertical_back_gap, c.v_act, 12'h0);
            s_nxt.de = c.on && h_in && v_in;
            // Sync pulses open each line and frame, closing the previous one
            s_nxt.hs = (c.on && c.sync_en && s_r.hcnt < CW'(c.hsw)) ? c.hs_hi : ~c.hs_hi;
            s_nxt.vs = (c.on && c.sync_en && s_r.vcnt < CW'(c.vsw)) ? c.vs_hi : ~c.vs_hi;
            s_nxt.rgb = 18'h0;
            if (s_nxt.de)
            begin
                // An empty holding word sends black rather than stalling the panel
                s_nxt.rgb  = s_r.full ? trunc(s_r.hold) : 18'h0;
                s_nxt.full = 1'b0;
            end
            if (!c.on)
            begin
                s_nxt.hcnt = '0;
                s_nxt.vcnt = '0;
            end
            else if (s_r.hcnt >= htot - CW'(1))
            begin
                s_nxt.hcnt = '0;
                s_nxt.vcnt = (s_r.vcnt >= vtot - CW'(1)) ? '0 : s_r.vcnt + CW'(1);
            end
            else
                s_nxt.hcnt = s_r.hcnt + CW'(1);
        end
        // One-word holding stage toward the pixel source
        if (s_r.rdy && i_pix_valid)
        begin
            s_nxt.hold = i_pix_data;
            s_nxt.full = 1'b1;
        end
        s_nxt.rdy = !s_nxt.full;
    end

    // State register; sync pins idle high under the reset setting
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_r     <= '0;
            s_r.hs  <= 1'b1;
            s_r.vs  <= 1'b1;
            s_r.rdy <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign o_pix_ready       = s_r.rdy;
    assign o_line_sync_pin   = s_r.hs;
    assign o_frame_sync_pin  = s_r.vs;
    assign o_pixel_valid_pin = s_r.de;
    assign o_pixel_clock_pin = s_r.pclk;
    assign o_rgb_pixel_bus   = s_r.rgb;

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    assign htot_q = span(s_r.cfg.horizontal_back_gap, s_r.cfg.h_act, s_r.cfg.horizontal_front_gap);

    // Run length of valid pixel slots in the current line
    logic [CW-1:0] de_run;
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            de_run <= '0;
        else if (adv)
            de_run <= s_nxt.de ? de_run + CW'(1) : '0;
    end

    sequence line_wrap_s;
        adv && s_r.cfg.on && s_r.hcnt == htot_q - CW'(1);
    endsequence

    // Judged after the next slot edge, with the settings that edge used
    sequence sync_wanted_s;
        s_r.cfg.on && s_r.cfg.sync_en && s_r.cfg.hsw != 12'h0;
    endsequence

    de_run_len_a: assert property (
        de_run <= CW'(s_r.cfg.h_act))
        else $error("valid held longer than the active width");

    back_gap_a: assert property (
        $rose(o_pixel_valid_pin) |-> $past(s_r.hcnt) == CW'(s_r.cfg.horizontal_back_gap))
        else $error("first valid pixel not after the back gap");

    fall_change_a: assert property (
        $past(s_r.cfg.pclk_hi) && $changed(o_rgb_pixel_bus) |-> $fell(o_pixel_clock_pin))
        else $error("data moved off the falling clock edge");

    rise_change_a: assert property (
        !$past(s_r.cfg.pclk_hi) && $changed(o_rgb_pixel_bus) |-> $rose(o_pixel_clock_pin))
        else $error("data moved off the rising clock edge");

    red_field_a: assert property (
        $rose(o_pixel_valid_pin) && $past(s_r.full)
        |-> o_rgb_pixel_bus[17:12] == $past(s_r.hold[3*IN_BITS-1 -: OB]))
        else $error("red bits not on the top of the bus");

    trunc_pix_a: assert property (
        $rose(o_pixel_valid_pin) && $past(s_r.full)
        |-> o_rgb_pixel_bus == trunc($past(s_r.hold)))
        else $error("pixel not truncated from the held word");

    cfg_frame_a: assert property (
        $changed(s_r.cfg) |-> $past(s_r.hcnt) == '0 && $past(s_r.vcnt) == '0)
        else $error("settings changed inside a frame");

    sync_off_a: assert property (
        !s_r.cfg.sync_en |-> o_line_sync_pin != s_r.cfg.hs_hi && o_frame_sync_pin != s_r.cfg.vs_hi)
        else $error("sync pulsed while syncs are off");

    line_len_a: assert property (
        line_wrap_s |=> s_r.hcnt == '0)
        else $error("line did not end at its total length");

    line_sync_a: assert property (
        line_wrap_s ##SLOT_AFTER sync_wanted_s |-> o_line_sync_pin == s_r.cfg.hs_hi)
        else $error("no line sync after the end of a line");

    frame_sync_a: assert property (
        adv && s_r.cfg.on && s_r.cfg.sync_en && s_r.hcnt != '0 && s_r.vcnt < CW'(s_r.cfg.vsw)
        |=> o_frame_sync_pin == s_r.cfg.vs_hi)
        else $error("frame sync missing in its lines");

    mode_gate_a: assert property (
        !s_r.cfg.on |-> !o_pixel_valid_pin)
        else $error("valid driven outside TFT colour mode");

endmodule

// *** test/stp_panel_model.sv ***
// Behavioural TFT colour panel that latches pixels and checks line shape
module stp_panel_model (
    input  wire logic        i_rst,
    input  wire logic        i_pclk,
    input  wire logic        i_pol_hi,
    input  wire logic        i_hs_hi,
    input  wire logic        i_vs_hi,
    input  wire logic        i_line_sync,
    input  wire logic        i_frame_sync,
    input  wire logic        i_valid,
    input  wire logic [17:0] i_rgb,
    input  wire logic [11:0] i_width,
    input  wire logic [11:0] i_height,
    output logic [17:0]      o_px,
    output int               o_cnt,
    output int               o_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    int col = 0;
    int row = 0;
    initial o_cnt = 0;
    initial o_bad = 0;
    // ************************************************************
    // Latch edge is the one opposite the data-change edge
    // ************************************************************
    always @(i_pclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            col = 0;
            row = 0;
        end
        else if (i_pclk === i_pol_hi)
        begin
            // One pixel per clock, only while valid is up
            if (i_valid === 1'b1)
            begin
                o_px <= i_rgb;
                o_cnt <= o_cnt + 1;
                col = col + 1;
            end
            // Line sync closes a line; a short or long line is a fault
            if (i_line_sync === i_hs_hi && col != 0)
            begin
                if (col != i_width) o_bad <= o_bad + 1;
                row = row + 1;
                col = 0;
            end
            // Frame sync restarts the line index
            if (i_frame_sync === i_vs_hi)
            begin
                if (row != 0 && row != i_height) o_bad <= o_bad + 1;
                row = 0;
            end
        end
    end
endmodule

// *** test/sync_tft_pixel_port_tb.sv ***
// Self-checking bench for the TFT colour pixel port
`include "stp_consts.svh"
module sync_tft_pixel_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 0, i_rst = 1;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, pready, hs, vs, dv, pclk;
    logic [1:0]  bresp, rresp;
    logic [23:0] pd = 0;
    logic        pv = 0, src_on = 0, pol_hi = 1, hs_hi = 1, vs_hi = 0;
    logic [17:0] rgb, ppx;
    int          pcnt, pbad, seen = 0, cyc = 0, k = 0, base;
    logic [31:0] ctl;
    int          fail_count = 0, n_compared = 0;
    logic [17:0] expq[$];
    always #10 i_clk_sys = ~i_clk_sys;
    stp_top stp_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_pix_data(pd), .i_pix_valid(pv), .o_pix_ready(pready), .o_line_sync_pin(hs),
        .o_frame_sync_pin(vs), .o_pixel_valid_pin(dv), .o_pixel_clock_pin(pclk),
        .o_rgb_pixel_bus(rgb));
    stp_panel_model stp_panel_model_inst (.i_rst(i_rst), .i_pclk(pclk), .i_pol_hi(pol_hi),
        .i_hs_hi(hs_hi), .i_vs_hi(vs_hi), .i_line_sync(hs), .i_frame_sync(vs), .i_valid(dv),
        .i_rgb(rgb), .i_width(12'h005), .i_height(12'h003), .o_px(ppx), .o_cnt(pcnt),
        .o_bad(pbad));
    // Keep the upper six bits of each colour, nothing else
    function automatic logic [17:0] trunc(input logic [23:0] d);
        return {d[23:18], d[15:10], d[7:2]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge i_clk_sys);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", er, bresp);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge i_clk_sys);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge i_clk_sys);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk("rdata", ed, rdata);
        chk("rresp", er, rresp);
    endtask
    // Pixel source: corner colours first, then random; taken pixels queued
    // Forked from the seeded thread so its random stream follows the seed
    task automatic src_loop();
        forever
        begin
            @(posedge i_clk_sys);
            if (pv && pready) expq.push_back(trunc(pd));
            if (!pv || pready)
            begin
                pv <= src_on;
                pd <= (k == 0) ? 24'hffffff : (k == 1) ? 24'h030303 : 24'($urandom);
                if (src_on) k <= k + 1;
            end
        end
    endtask
    // Every latched pixel must be the next one offered, cut to six bits
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            print_verdict();
        end
        else if (pcnt != seen)
        begin
            seen = pcnt;
            chk("pixel", expq.pop_front(), ppx);
        end
    end
    initial
    begin
        void'($urandom(18));
        fork
            src_loop();
        join_none
        // Third pass runs with syncs off: panel gets valid, clock and data only
        for (int run = 0; run < 3; run++)
        begin
            i_rst <= 1;
            src_on <= 0;
            ctl = (run == 0) ? 32'h37 : (run == 1) ? 32'h39 : 32'h29;
            repeat (20) @(posedge i_clk_sys);
            expq.delete();
            k <= 0;
            i_rst <= 0;
            pol_hi <= (run == 0);
            hs_hi <= (run == 0);
            vs_hi <= (run != 0);
            axr(`STP_OFF_SIZE, `STP_RST_SIZE, `STP_RESP_OK);
            axw(`STP_OFF_SIZE, 32'h0003_0005, `STP_RESP_OK);
            axw(`STP_OFF_HGAP, 32'h0002_0003, `STP_RESP_OK);
            axw(`STP_OFF_VGAP, 32'h0001_0002, `STP_RESP_OK);
            axw(`STP_OFF_SYNC, 32'h0001_0002, `STP_RESP_OK);
            axw(8'h18, 32'h1234_5678, `STP_RESP_ERR);
            axr(8'h18, 32'h0, `STP_RESP_ERR);
            // A panel kind other than colour must send the panel no valid pixels
            base = pcnt;
            src_on <= 1;
            axw(`STP_OFF_CTRL, 32'h0000_0051, `STP_RESP_OK);
            repeat (200) @(posedge i_clk_sys);
            chk("idle_pixels", base, pcnt);
            axw(`STP_OFF_CTRL, ctl, `STP_RESP_OK);
            axr(`STP_OFF_CTRL, ctl, `STP_RESP_OK);
            while (pcnt - base < 30) @(posedge i_clk_sys);
            chk("line_shape", 0, pbad);
            if (run == 2)
                chk("sync_idle", {~hs_hi, ~vs_hi}, {hs, vs});
        end
        print_verdict();
    end
endmodule
